// File: logic/sdc_cal_ctrl.sv
// Calibration controller for the sigma-delta converter
//
// Overview of operation
// - Writing start bit begins calibration of enabled channels
// - Mode field picks internal, offset or gain
// - Single-ended channels never get correction values from a calibration run
// - Result fields frozen while calibration runs
// - Internal mode yields offset and gain on each enabled differential channel
// - Internal run ends with complete event
// - Offset correction makes offset input convert zero
// - Gain correction maps input span to full scale
// - External run handles one channel, one value
// - Every external run raises complete event
// - Correction registers writable to restore saved values
// - Several conversions per value, errors averaged
`timescale 1ns/100ps
`default_nettype none
module sdc_cal_ctrl
  import sdc_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
)(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CAL_START_BIT,
  input wire logic [1:0] CAL_MODE_FIELD,
  input wire logic [CHANNELS-1:0] CHANNEL_CAL_ENABLE,
  input wire logic [CHANNELS-1:0] INPUT_MODE_SELECT,
  input wire logic CORR_WR,
  input wire logic [CHN_W-1:0] CORR_WR_CHAN,
  input wire sdc_corr_s CORR_WR_DATA,
  input wire logic CONV_VALID,
  input wire logic [CHN_W-1:0] CONV_CHAN,
  input wire logic CONV_STATUS,
  input wire logic signed [RES_W-1:0] CONV_DATA,
  input wire logic [CHN_W-1:0] CORR_RD_CHAN,
  output logic CONV_REQ,
  output logic [CHN_W-1:0] CONV_REQ_CHAN,
  output sdc_src_e CONV_SRC,
  output sdc_result_s CONVERSION_RESULT_REG,
  output sdc_corr_s CORR_RD_DATA,
  output logic CAL_BUSY,
  output logic CAL_COMPLETE_IRQ
);

  // =====================================================================
  // State and storage
  typedef enum logic [2:0] {
    ST_IDLE, ST_PICK, ST_REQ, ST_WAIT, ST_STORE, ST_DONE
  } sdc_state_e;

  sdc_state_e state_ff, nxt_state;
  logic [1:0] mode_ff;
  logic [CHANNELS-1:0] todo_ff;
  logic [CHN_W-1:0] chan_ff;
  logic phase_ff;
  logic req_ff;
  logic irq_ff;
  logic avg_clear;
  logic signed [RES_W-1:0] mean;
  logic [2:0] count;
  sdc_result_s result_ff;
  logic [CORR_W-1:0] gain_ff [CHANNELS];
  logic [CORR_W-1:0] ofs_ff [CHANNELS];

  // Lowest pending channel index
  function automatic logic [CHN_W-1:0] first_set(
    input logic [CHANNELS-1:0] v
  );
    logic [CHN_W-1:0] r;
    r = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = CHN_W'(i);
      end
    end
    return r;
  endfunction

  // Gain factor scaled so the measured span reaches full scale
  function automatic logic [CORR_W-1:0] gain_of(
    input logic signed [RES_W-1:0] span
  );
    logic [2*RES_W-1:0] num;
    num = {{RES_W{1'b0}}, FULL_POS} << (RES_W - 2);
    if (span <= 0) begin
      return GAIN_UNITY;
    end
    return CORR_W'(num / {{RES_W{1'b0}}, span});
  endfunction

  // =====================================================================
  // Decoding
  wire logic idle = (state_ff == ST_IDLE);
  // Differential-only targets; unused mode code 11 calibrates nothing
  wire logic mode_ok = (CAL_MODE_FIELD != 2'h3);
  wire logic [CHANNELS-1:0] targets =
    CHANNEL_CAL_ENABLE & ~INPUT_MODE_SELECT;
  // A start while busy is dropped, not queued
  wire logic start = CAL_START_BIT && idle && mode_ok;
  wire logic is_int = (mode_ff == MODE_INTERNAL);
  wire logic conv_hit = CONV_VALID && (state_ff == ST_WAIT) &&
    (CONV_CHAN == chan_ff);
  wire logic run_done = (count == 3'(NUM_CONV));
  // Internal: offset pass uses zero input, gain pass the internal ref
  wire logic last_step = !is_int || phase_ff;
  wire logic [CHANNELS-1:0] todo_left =
    todo_ff & ~(CHANNELS'(1) << chan_ff);
  wire logic signed [RES_W-1:0] ofs_now = RES_W'(ofs_ff[chan_ff]);
  wire logic signed [RES_W-1:0] int_span = mean - ofs_now;

  assign avg_clear = (state_ff == ST_PICK) || (state_ff == ST_STORE);

  sdc_avg u_avg (
    .CLOCK(CLOCK),
    .RSTN(RSTN),
    .CLEAR(avg_clear),
    .SAMPLE_VALID(conv_hit && !run_done),
    .SAMPLE(CONV_DATA),
    .MEAN(mean),
    .COUNT(count)
  );

  // =====================================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:  if (start) nxt_state = (|targets) ? ST_PICK : ST_DONE;
      ST_PICK:  nxt_state = ST_REQ;
      ST_REQ:   nxt_state = ST_WAIT;
      ST_WAIT:  if (run_done) nxt_state = ST_STORE;
      ST_STORE: begin
        if (!last_step) begin
          nxt_state = ST_REQ;
        end else if (is_int && |todo_left) begin
          nxt_state = ST_PICK;
        end else begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_INTERNAL;
      todo_ff <= '0;
      chan_ff <= '0;
      phase_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        mode_ff <= CAL_MODE_FIELD;
        todo_ff <= targets;
      end
      if (state_ff == ST_PICK) begin
        chan_ff <= first_set(todo_ff);
        phase_ff <= 1'b0;
      end
      if (state_ff == ST_STORE) begin
        phase_ff <= !phase_ff;
        if (last_step) begin
          todo_ff <= todo_left;
        end
      end
    end
  end

  // Conversion request to the modulator, one pulse per stored value
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= (state_ff == ST_REQ);
    end
  end

  assign CONV_REQ = req_ff;
  assign CONV_REQ_CHAN = chan_ff;
  assign CONV_SRC = !is_int ? SRC_EXT_PIN :
    (phase_ff ? SRC_INT_REF : SRC_ZERO);

  // =====================================================================
  // Correction registers
  genvar g;
  for (g = 0; g < CHANNELS; g++) begin : g_corr
    wire logic sel = (state_ff == ST_STORE) && (chan_ff == CHN_W'(g));
    wire logic gain_step = (mode_ff == MODE_EXT_GAIN) || (is_int && phase_ff);
    always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
        gain_ff[g] <= GAIN_UNITY;
        ofs_ff[g] <= OFS_RESET;
      end else if (sel && !gain_step) begin
        ofs_ff[g] <= CORR_W'(mean);
      end else if (sel && gain_step) begin
        gain_ff[g] <= gain_of(is_int ? int_span - INT_GAIN_REF +
          INT_GAIN_REF : mean - ofs_now);
      end else if (CORR_WR && idle && CORR_WR_CHAN == CHN_W'(g)) begin
        gain_ff[g] <= CORR_WR_DATA.gain;
        ofs_ff[g] <= CORR_WR_DATA.ofs;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      CORR_RD_DATA <= '0;
    end else if (int'(CORR_RD_CHAN) < CHANNELS) begin
      CORR_RD_DATA <= '{gain: gain_ff[CORR_RD_CHAN],
        ofs: ofs_ff[CORR_RD_CHAN]};
    end else begin
      CORR_RD_DATA <= '0;
    end
  end

  // =====================================================================
  // Result register and completion
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      result_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (CONV_VALID && idle) begin
        result_ff <= '{chan: CONV_CHAN, status: CONV_STATUS,
          data: CONV_DATA};
      end
      irq_ff <= (state_ff == ST_DONE);
    end
  end

  assign CONVERSION_RESULT_REG = result_ff;
  assign CAL_BUSY = !idle;
  assign CAL_COMPLETE_IRQ = irq_ff;

  // =====================================================================
  // Checks
  sequence s_started;
    start && |targets;
  endsequence

  chk_result_frozen: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !idle |=> $stable(result_ff) || $past(idle))
    else $error("result register changed during calibration");

  chk_start_ignored: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    (CAL_START_BIT && !idle && state_ff != ST_DONE) |=>
    !idle && $stable(mode_ff))
    else $error("busy start disturbed the sequence");

  chk_start_runs: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_started |=> state_ff == ST_PICK)
    else $error("start did not begin calibration");

  chk_done_irq: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_ff == ST_DONE |=> CAL_COMPLETE_IRQ ##1 !CAL_COMPLETE_IRQ)
    else $error("complete pulse missing or too long");

  chk_irq_cause: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CAL_COMPLETE_IRQ |-> $past(state_ff == ST_DONE))
    else $error("complete pulse without end of run");

  chk_single_ended: assert property (@(posedge CLOCK) disable iff (!RSTN)
    start |=> (todo_ff & $past(INPUT_MODE_SELECT)) == '0)
    else $error("single-ended channel queued");

  chk_conv_count: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state_ff == ST_STORE |-> count == 3'(NUM_CONV))
    else $error("stored before all conversions");

  chk_ext_one_op: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (state_ff == ST_STORE && !is_int) |=> state_ff == ST_DONE)
    else $error("external run did more than one value");

endmodule
`default_nettype wire

// File: logic/sdc_pkg.sv
// Package for the sigma-delta calibration controller: constants and types
package sdc_pkg;

  localparam int NUM_CH = 5;
  localparam int RES_W = 24;
  localparam int CHN_W = 3;
  localparam int CORR_W = 24;
  localparam int NUM_CONV = 4;
  localparam int SUM_W = RES_W + 3;

  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_EXT_OFS = 2'h1;
  localparam logic [1:0] MODE_EXT_GAIN = 2'h2;

  localparam logic signed [RES_W-1:0] FULL_POS = 24'h7f_ffff;
  localparam logic [CORR_W-1:0] GAIN_UNITY = 24'h40_0000;
  localparam logic [CORR_W-1:0] OFS_RESET = 24'h00_0000;
  localparam logic signed [RES_W-1:0] INT_GAIN_REF = 24'h40_0000;
  localparam logic [2:0] LOG2_CONV = 3'h2;

  typedef enum logic [1:0] {
    SRC_ZERO,
    SRC_INT_REF,
    SRC_EXT_PIN
  } sdc_src_e;

  typedef struct packed {
    logic [CHN_W-1:0] chan;
    logic status;
    logic [RES_W-1:0] data;
  } sdc_result_s;

  typedef struct packed {
    logic [CORR_W-1:0] gain;
    logic [CORR_W-1:0] ofs;
  } sdc_corr_s;

endpackage

// File: logic/sdc_avg.sv
// Accumulator averaging a run of calibration conversions
`timescale 1ns/100ps
`default_nettype none
module sdc_avg
  import sdc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CLEAR,
  input wire logic SAMPLE_VALID,
  input wire logic signed [RES_W-1:0] SAMPLE,
  output logic signed [RES_W-1:0] MEAN,
  output logic [2:0] COUNT
);

  // =====================================================================
  // Accumulation
  logic signed [SUM_W-1:0] sum_ff;
  logic [2:0] cnt_ff;
  wire logic signed [SUM_W-1:0] nxt_sum = sum_ff + SUM_W'(SAMPLE);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sum_ff <= '0;
      cnt_ff <= '0;
    end else if (CLEAR) begin
      sum_ff <= '0;
      cnt_ff <= '0;
    end else if (SAMPLE_VALID) begin
      sum_ff <= nxt_sum;
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  assign MEAN = RES_W'(sum_ff >>> LOG2_CONV);
  assign COUNT = cnt_ff;

endmodule
`default_nettype wire

// File: tb/sdc_cal_ctrl_test.sv
// Self-checking bench for the calibration controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module sdc_cal_ctrl_test import sdc_pkg::*; ;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic corr_wr = 1'b0;
  logic cv = 1'b0;
  logic cv_st = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [4:0] en = 5'h00;
  logic [4:0] se = 5'h00;
  logic [2:0] wr_chan = 3'h0;
  logic [2:0] cv_chan = 3'h0;
  logic [2:0] rd_chan = 3'h0;
  logic [2:0] ch;
  logic signed [23:0] cv_data = 24'h00_0000;
  sdc_corr_s wr_data = '0;
  logic req, busy, irq;
  logic [2:0] req_chan;
  sdc_src_e src;
  sdc_result_s res, saved;
  sdc_corr_s rd;
  longint m_ofs[5], m_gain[5];
  int fail_count = 0;
  int n_tests = 0;
  int irq_n = 0;
  int seed = 50703;

  sdc_cal_ctrl #(.CHANNELS(5)) dut (
    .CLOCK(clock), .RSTN(rstn), .CAL_START_BIT(start),
    .CAL_MODE_FIELD(mode), .CHANNEL_CAL_ENABLE(en),
    .INPUT_MODE_SELECT(se), .CORR_WR(corr_wr), .CORR_WR_CHAN(wr_chan),
    .CORR_WR_DATA(wr_data), .CONV_VALID(cv), .CONV_CHAN(cv_chan),
    .CONV_STATUS(cv_st), .CONV_DATA(cv_data), .CORR_RD_CHAN(rd_chan),
    .CONV_REQ(req), .CONV_REQ_CHAN(req_chan), .CONV_SRC(src),
    .CONVERSION_RESULT_REG(res), .CORR_RD_DATA(rd), .CAL_BUSY(busy),
    .CAL_COMPLETE_IRQ(irq)
  );

  always #2 clock = ~clock;
  always @(posedge clock) if (irq === 1'b1) irq_n++;

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Readback lags one cycle, so two edges are allowed
  task automatic rd_chk(input logic [2:0] c);
    rd_chan <= c;
    repeat (2) @(negedge clock);
    if (c < 3'h5) `CHK(rd, {24'(m_gain[c]), 24'(m_ofs[c])})
    else `CHK(rd, 48'h0)
  endtask

  // One step: a stray conversion of another channel, then four good ones
  task automatic serve(input int step, input longint span,
                       input logic [2:0] exp_ch);
    int k;
    logic ofs;
    longint v;
    k = 0;
    while (req !== 1'b1 && k < 300) begin
      @(negedge clock);
      k++;
    end
    if (k >= 300) begin
      fail_count++;
      print_verdict();
    end
    ch = req_chan;
    `CHK(req_chan, exp_ch)
    ofs = (mode == MODE_EXT_OFS) || (mode == MODE_INTERNAL && step % 2 == 0);
    if (mode != MODE_INTERNAL) `CHK(src, SRC_EXT_PIN)
    else if (ofs) `CHK(src, SRC_ZERO)
    else `CHK(src, SRC_INT_REF)
    v = ofs ? longint'($random(seed) % 4000) : m_ofs[ch] + span;
    cv <= 1'b1;
    cv_chan <= ch + 3'h1;
    cv_data <= 24'h12_3456;
    @(negedge clock);
    `CHK(req, 1'b0)
    for (int i = 0; i < 4; i++) begin
      cv_chan <= ch;
      cv_data <= 24'(v + 2 * i - 3);
      @(negedge clock);
    end
    cv <= 1'b0;
    if (ofs) m_ofs[ch] = v;
    else m_gain[ch] = (64'h7f_ffff * 64'h40_0000) / span;
    `CHK(res, saved)
  endtask

  // Start held two edges and a correction write while busy: both ignored
  task automatic cal(input logic [1:0] m, input logic [4:0] e,
                     input logic [4:0] s, input int steps, input longint sp);
    int k;
    int q[$];
    // Single scan and zero input offset adjust are kept upstream
    for (int c = 0; c < 5; c++) if (e[c] && !s[c]) q.push_back(c);
    mode <= m;
    en <= e;
    se <= s;
    saved = res;
    irq_n = 0;
    start <= 1'b1;
    @(negedge clock);
    `CHK(busy, 1'b1)
    corr_wr <= 1'b1;
    wr_chan <= 3'h3;
    wr_data <= {24'h12_3456, 24'h65_4321};
    @(negedge clock);
    start <= 1'b0;
    corr_wr <= 1'b0;
    for (int i = 0; i < steps; i++) serve(i, sp, 3'(q[i / 2]));
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    if (k >= 100) begin
      fail_count++;
      print_verdict();
    end
    @(negedge clock);
    `CHK(irq, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(irq_n, 1)
    `CHK(res, saved)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 5; i++) begin
      m_gain[i] = 64'h40_0000;
      m_ofs[i] = 0;
    end
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(3'(i));
    cv <= 1'b1;
    cv_chan <= 3'h2;
    cv_st <= 1'b1;
    cv_data <= 24'h00_1234;
    @(negedge clock);
    cv <= 1'b0;
    @(negedge clock);
    `CHK(res, {3'h2, 1'b1, 24'h00_1234})
    // Offset then gain on a random channel, two span sizes
    for (int r = 0; r < 4; r++) begin
      ch = 3'($unsigned($random(seed)) % 5);
      cal(MODE_EXT_OFS, 5'h01 << ch, 5'h00, 1, 0);
      cal(MODE_EXT_GAIN, 5'h01 << ch, 5'h00, 1,
          64'h20_0000 << r[0]);
      for (int i = 0; i < 5; i++) rd_chk(3'(i));
    end
    // Single-ended target and empty target set finish with no steps
    cal(MODE_EXT_OFS, 5'h04, 5'h04, 0, 0);
    cal(MODE_INTERNAL, 5'h00, 5'h00, 0, 0);
    cal(MODE_INTERNAL, 5'h15, 5'h04, 4, 64'h40_0000);
    for (int i = 0; i < 5; i++) rd_chk(3'(i));
    // Reserved mode code starts nothing
    mode <= 2'h3;
    en <= 5'h01;
    start <= 1'b1;
    @(negedge clock);
    start <= 1'b0;
    `CHK(busy, 1'b0)
    @(negedge clock);
    `CHK(irq, 1'b0)
    // Restoring saved values while idle
    m_gain[3] = $unsigned($random(seed)) & 32'h00ff_ffff;
    m_ofs[3] = $unsigned($random(seed)) & 32'h00ff_ffff;
    corr_wr <= 1'b1;
    wr_chan <= 3'h3;
    wr_data <= {24'(m_gain[3]), 24'(m_ofs[3])};
    @(negedge clock);
    corr_wr <= 1'b0;
    rd_chk(3'h3);
    print_verdict();
  end
endmodule
`default_nettype wire
